// *** design/gpio_pkg.sv ***
// Package: register map, field layout and reset values of the two-port GPIO block
package gpio_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] PORT_ONE_DIRECTION_OFS     = 8'h00;
  localparam logic [7:0] PORT_ONE_OUTPUT_LATCH_OFS  = 8'h04;
  localparam logic [7:0] PORT_ONE_PULLUP_ENABLE_OFS = 8'h08;
  localparam logic [7:0] PORT_TWO_DIRECTION_OFS     = 8'h0C;
  localparam logic [7:0] PORT_TWO_OUTPUT_LATCH_OFS  = 8'h10;
  localparam logic [7:0] PIN_FUNCTION_SELECT_OFS    = 8'h14;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam logic [7:0] PORT_ONE_PIN_MASK  = 8'hF7;
  localparam logic [7:0] PORT_ONE_RSVD_ONES = 8'h08;
  localparam logic [7:0] PORT_TWO_PIN_MASK  = 8'h07;
  localparam logic [7:0] PORT_TWO_RSVD_ONES = 8'hF8;
  localparam logic [7:0] PIN_FUNCTION_MASK  = 8'h92;
  localparam logic [7:0] PIN_FUNCTION_RSVD  = 8'h08;
  localparam int         FN_IRQ_TRIGGER_BIT = 7;
  localparam int         FN_IRQ_OTHER_BIT   = 4;
  localparam int         FN_TRANSMIT_BIT    = 1;
  localparam int         TRANSMIT_PIN_BIT   = 2;

  // ------------------------------------------------------------------
  // Reset values and bus answers
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic [7:0] p1_dir;
    logic [7:0] p1_latch;
    logic [7:0] p1_pullup;
    logic [7:0] p2_dir;
    logic [7:0] p2_latch;
    logic [7:0] pin_fn;
  } regs_type;

  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       aw_held;
    logic [7:0] aw_addr;
    logic       w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_type;

  typedef struct packed {
    logic [7:0] p1_out;
    logic [7:0] p1_oe;
    logic [7:0] p1_pull;
    logic [7:0] p2_out;
    logic [7:0] p2_oe;
    logic       irq_a;
    logic       irq_c;
    logic       trig;
  } pins_type;

  typedef struct packed {
    regs_type regs;
    bus_type  bus;
    pins_type pins;
  } state_type;

endpackage

// *** design/gpio_ports_one_and_two.sv ***
// Module: two-port GPIO block with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Port-one general pin drives when its direction bit is 1, else input.
// - Port one has pins 7-4 and 2-0; bit 3 is reserved everywhere.
// - Port-one latch holds the value driven on port-one output pins.
// - Port-one latch read returns stored value where direction is 1.
// - Port-one latch read returns live pin level where direction is 0.
// - Bit 3 of port-one latch and pull-up registers reads as 1.
// - Port-one pull-up acts only while the pin is not driven: direction bit 0 or alternate input selected.
// - Input pin pull-up is on when its bit is 1, off when 0.
// - Function bit 7 makes pin 7 interrupt/trigger input; bit 4 makes pin 4 interrupt input.
// - Port two has pins 2-0; direction 1 output, 0 input.
// - Port-two latch holds output value for port-two output pins.
// - Port-two latch read: stored value for outputs, pin level for inputs.
// - Bits 7-3 of the port-two latch read as 1.
// - Pin-function and serial-unit settings override port-two GPIO settings.
// - Function bits 7, 4, 1 select trigger, interrupt and transmit pins.
module gpio_ports_one_and_two (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Port-one pins
  input  wire logic [7:0]  port_one_in,
  output var  logic [7:0]  port_one_out,
  output var  logic [7:0]  port_one_oe,
  output var  logic [7:0]  port_one_pullup_on,
  // Port-two pins
  input  wire logic [7:0]  port_two_in,
  output var  logic [7:0]  port_two_out,
  output var  logic [7:0]  port_two_oe,
  // Alternate functions
  output var  logic        ext_interrupt_line_a,
  output var  logic        ext_interrupt_line_c,
  output var  logic        timer_trigger_input,
  input  wire logic        serial_unit_txd,
  input  wire logic        serial_unit_rx_enable,
  input  wire logic        serial_unit_clk_enable,
  input  wire logic        serial_unit_clk_out,
  input  wire logic        serial_unit_clk_oe
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  gpio_pkg::state_type state_r;
  gpio_pkg::state_type state_nxt;

  logic [7:0]  rd_byte;
  logic [1:0]  rd_resp;
  logic [7:0]  wr_byte;
  logic        wr_fire;
  logic        wr_hit;
  logic [7:0]  wr_addr;
  logic [7:0]  p1_dir_eff;
  logic [7:0]  p2_dir_eff;

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    rd_resp = gpio_pkg::RESP_OKAY;
    unique case (s_axi_araddr)
      // Direction registers are write-only and read back as zero
      gpio_pkg::PORT_ONE_DIRECTION_OFS: begin
        rd_byte = 8'h00;
      end
      gpio_pkg::PORT_ONE_OUTPUT_LATCH_OFS: begin
        rd_byte = ((state_r.regs.p1_dir & state_r.regs.p1_latch)
                 | (~state_r.regs.p1_dir & port_one_in))
                 & gpio_pkg::PORT_ONE_PIN_MASK
                 | gpio_pkg::PORT_ONE_RSVD_ONES;
      end
      gpio_pkg::PORT_ONE_PULLUP_ENABLE_OFS: begin
        rd_byte = state_r.regs.p1_pullup | gpio_pkg::PORT_ONE_RSVD_ONES;
      end
      gpio_pkg::PORT_TWO_DIRECTION_OFS: begin
        rd_byte = 8'h00;
      end
      gpio_pkg::PORT_TWO_OUTPUT_LATCH_OFS: begin
        rd_byte = ((state_r.regs.p2_dir & state_r.regs.p2_latch)
                 | (~state_r.regs.p2_dir & port_two_in))
                 & gpio_pkg::PORT_TWO_PIN_MASK
                 | gpio_pkg::PORT_TWO_RSVD_ONES;
      end
      gpio_pkg::PIN_FUNCTION_SELECT_OFS: begin
        rd_byte = state_r.regs.pin_fn | gpio_pkg::PIN_FUNCTION_RSVD;
      end
      default: begin
        rd_resp = gpio_pkg::RESP_SLVERR;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  // Address and data may arrive in either order; both are parked first
  assign wr_fire = state_r.bus.aw_held & state_r.bus.w_held & ~state_r.bus.bvalid;
  assign wr_addr = state_r.bus.aw_addr;
  // Only the low byte lane holds register bits; other lanes are ignored
  assign wr_byte = state_r.bus.w_strb[0] ? state_r.bus.w_data[7:0] : 8'h00;
  assign wr_hit  = (wr_addr == gpio_pkg::PORT_ONE_DIRECTION_OFS)
                 | (wr_addr == gpio_pkg::PORT_ONE_OUTPUT_LATCH_OFS)
                 | (wr_addr == gpio_pkg::PORT_ONE_PULLUP_ENABLE_OFS)
                 | (wr_addr == gpio_pkg::PORT_TWO_DIRECTION_OFS)
                 | (wr_addr == gpio_pkg::PORT_TWO_OUTPUT_LATCH_OFS)
                 | (wr_addr == gpio_pkg::PIN_FUNCTION_SELECT_OFS);

  // ------------------------------------------------------------------
  // Pin function resolution
  // ------------------------------------------------------------------
  always_comb begin
    p1_dir_eff = state_r.regs.p1_dir & gpio_pkg::PORT_ONE_PIN_MASK;
    // Alternate inputs force the pin off the output driver
    if (state_r.regs.pin_fn[gpio_pkg::FN_IRQ_TRIGGER_BIT]) begin
      p1_dir_eff[7] = 1'b0;
    end
    if (state_r.regs.pin_fn[gpio_pkg::FN_IRQ_OTHER_BIT]) begin
      p1_dir_eff[4] = 1'b0;
    end
    p2_dir_eff = state_r.regs.p2_dir & gpio_pkg::PORT_TWO_PIN_MASK;
    // Receive pin 1 becomes input; clock pin 0 follows the serial unit
    if (serial_unit_rx_enable) begin
      p2_dir_eff[1] = 1'b0;
    end
    if (serial_unit_clk_enable) begin
      p2_dir_eff[0] = serial_unit_clk_oe;
    end
    if (state_r.regs.pin_fn[gpio_pkg::FN_TRANSMIT_BIT]) begin
      p2_dir_eff[gpio_pkg::TRANSMIT_PIN_BIT] = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;

    // Write address and data channels
    // Ready stays low from its handshake until the write answer is taken
    state_nxt.bus.awready = ~state_r.bus.aw_held & ~state_r.bus.bvalid;
    state_nxt.bus.wready  = ~state_r.bus.w_held & ~state_r.bus.bvalid;
    if (s_axi_awvalid & state_r.bus.awready) begin
      state_nxt.bus.aw_held = 1'b1;
      state_nxt.bus.aw_addr = s_axi_awaddr;
      state_nxt.bus.awready = 1'b0;
    end
    if (s_axi_wvalid & state_r.bus.wready) begin
      state_nxt.bus.w_held = 1'b1;
      state_nxt.bus.w_data = s_axi_wdata;
      state_nxt.bus.w_strb = s_axi_wstrb;
      state_nxt.bus.wready = 1'b0;
    end

    if (wr_fire) begin
      state_nxt.bus.bvalid  = 1'b1;
      state_nxt.bus.bresp   = wr_hit ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
      state_nxt.bus.aw_held = 1'b0;
      state_nxt.bus.w_held  = 1'b0;
      state_nxt.bus.awready = 1'b0;
      state_nxt.bus.wready  = 1'b0;
      if (state_r.bus.w_strb[0]) begin
        unique case (wr_addr)
          gpio_pkg::PORT_ONE_DIRECTION_OFS: begin
            state_nxt.regs.p1_dir = wr_byte & gpio_pkg::PORT_ONE_PIN_MASK;
          end
          gpio_pkg::PORT_ONE_OUTPUT_LATCH_OFS: begin
            state_nxt.regs.p1_latch = wr_byte & gpio_pkg::PORT_ONE_PIN_MASK;
          end
          gpio_pkg::PORT_ONE_PULLUP_ENABLE_OFS: begin
            state_nxt.regs.p1_pullup = wr_byte & gpio_pkg::PORT_ONE_PIN_MASK;
          end
          gpio_pkg::PORT_TWO_DIRECTION_OFS: begin
            state_nxt.regs.p2_dir = wr_byte & gpio_pkg::PORT_TWO_PIN_MASK;
          end
          gpio_pkg::PORT_TWO_OUTPUT_LATCH_OFS: begin
            state_nxt.regs.p2_latch = wr_byte & gpio_pkg::PORT_TWO_PIN_MASK;
          end
          gpio_pkg::PIN_FUNCTION_SELECT_OFS: begin
            state_nxt.regs.pin_fn = wr_byte & gpio_pkg::PIN_FUNCTION_MASK;
          end
          default: begin
            state_nxt.regs = state_r.regs;
          end
        endcase
      end
    end
    if (state_r.bus.bvalid & s_axi_bready) begin
      state_nxt.bus.bvalid  = 1'b0;
      state_nxt.bus.awready = 1'b1;
      state_nxt.bus.wready  = 1'b1;
    end

    // Read channel: one read in flight; arready drops until rdata is taken
    if (s_axi_arvalid & state_r.bus.arready) begin
      state_nxt.bus.arready = 1'b0;
      state_nxt.bus.rvalid  = 1'b1;
      state_nxt.bus.rdata   = {24'h000000, rd_byte};
      state_nxt.bus.rresp   = rd_resp;
    end
    if (state_r.bus.rvalid & s_axi_rready) begin
      state_nxt.bus.rvalid  = 1'b0;
      state_nxt.bus.arready = 1'b1;
    end

    // Pins, registered so every output leaves a flip-flop
    state_nxt.pins.p1_oe   = p1_dir_eff;
    state_nxt.pins.p1_out  = state_r.regs.p1_latch & p1_dir_eff;
    state_nxt.pins.p1_pull = state_r.regs.p1_pullup & ~p1_dir_eff
                           & gpio_pkg::PORT_ONE_PIN_MASK;
    state_nxt.pins.p2_oe   = p2_dir_eff;
    state_nxt.pins.p2_out  = state_r.regs.p2_latch & p2_dir_eff;
    if (state_r.regs.pin_fn[gpio_pkg::FN_TRANSMIT_BIT]) begin
      state_nxt.pins.p2_out[gpio_pkg::TRANSMIT_PIN_BIT] = serial_unit_txd;
    end
    if (serial_unit_clk_enable) begin
      state_nxt.pins.p2_out[0] = serial_unit_clk_out & serial_unit_clk_oe;
    end
    // Alternate inputs idle high when not selected, the lines being active low
    state_nxt.pins.irq_c = state_r.regs.pin_fn[gpio_pkg::FN_IRQ_TRIGGER_BIT]
                         ? port_one_in[7] : 1'b1;
    state_nxt.pins.trig  = state_r.regs.pin_fn[gpio_pkg::FN_IRQ_TRIGGER_BIT]
                         ? port_one_in[7] : 1'b1;
    state_nxt.pins.irq_a = state_r.regs.pin_fn[gpio_pkg::FN_IRQ_OTHER_BIT]
                         ? port_one_in[4] : 1'b1;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= '0;
      state_r.regs.p1_dir    <= gpio_pkg::REG_RESET;
      state_r.regs.p1_latch  <= gpio_pkg::REG_RESET;
      state_r.regs.p1_pullup <= gpio_pkg::REG_RESET;
      state_r.regs.p2_dir    <= gpio_pkg::REG_RESET;
      state_r.regs.p2_latch  <= gpio_pkg::REG_RESET;
      state_r.regs.pin_fn    <= gpio_pkg::REG_RESET;
      state_r.bus.awready    <= 1'b1;
      state_r.bus.wready     <= 1'b1;
      state_r.bus.arready    <= 1'b1;
      state_r.pins.irq_a     <= 1'b1;
      state_r.pins.irq_c     <= 1'b1;
      state_r.pins.trig      <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign s_axi_awready        = state_r.bus.awready;
  assign s_axi_wready         = state_r.bus.wready;
  assign s_axi_bvalid         = state_r.bus.bvalid;
  assign s_axi_bresp          = state_r.bus.bresp;
  assign s_axi_arready        = state_r.bus.arready;
  assign s_axi_rvalid         = state_r.bus.rvalid;
  assign s_axi_rdata          = state_r.bus.rdata;
  assign s_axi_rresp          = state_r.bus.rresp;
  assign port_one_out         = state_r.pins.p1_out;
  assign port_one_oe          = state_r.pins.p1_oe;
  assign port_one_pullup_on   = state_r.pins.p1_pull;
  assign port_two_out         = state_r.pins.p2_out;
  assign port_two_oe          = state_r.pins.p2_oe;
  assign ext_interrupt_line_a = state_r.pins.irq_a;
  assign ext_interrupt_line_c = state_r.pins.irq_c;
  assign timer_trigger_input  = state_r.pins.trig;

endmodule

`default_nettype wire

// *** verif/gpio_board.sv ***
// Board model: resolves each package pin from device drive, board drive and, on port one only, pull-up
`timescale 1ns/1ns
`default_nettype none
module gpio_board (
  // Clock
  input  wire logic       aclk,
  // Device side
  input  wire logic [7:0] p1_oe,
  input  wire logic [7:0] p1_out,
  input  wire logic [7:0] p1_pull,
  input  wire logic [7:0] p2_oe,
  input  wire logic [7:0] p2_out,
  // Board drivers
  input  wire logic [7:0] drv1_en,
  input  wire logic [7:0] drv1_v,
  input  wire logic [7:0] drv2_en,
  input  wire logic [7:0] drv2_v,
  // Levels seen by the device
  output var  logic [7:0] p1_lvl,
  output var  logic [7:0] p2_lvl
);
  // Undriven pins wander so a floating read never passes for a clean value
  logic flip_r = 1'b0;
  always @(posedge aclk) flip_r <= ~flip_r;
  assign p1_lvl = (p1_oe & p1_out) | (~p1_oe & drv1_en & drv1_v)
                | (~p1_oe & ~drv1_en & (p1_pull | {8{flip_r}}));
  assign p2_lvl = (p2_oe & p2_out) | (~p2_oe & drv2_en & drv2_v) | (~p2_oe & ~drv2_en & {8{flip_r}});
endmodule
`default_nettype wire

// *** verif/gpio_props.sv ***
// Checker: bus answer timing, pin masking and alternate-function properties
`timescale 1ns/1ns
`default_nettype none
module gpio_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Pins
  input wire logic [7:0]  port_one_in,
  input wire logic [7:0]  port_one_oe,
  input wire logic [7:0]  port_one_pullup_on,
  input wire logic [7:0]  port_two_oe,
  input wire logic [7:0]  port_two_out,
  input wire logic        ext_interrupt_line_a,
  input wire logic        ext_interrupt_line_c,
  input wire logic        timer_trigger_input
);
  // ----------------------------------------------------------------
  // Read address tracking
  // ----------------------------------------------------------------
  logic [7:0] rd_addr_r;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr_r <= s_axi_araddr;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_read_taken; s_axi_arvalid && s_axi_arready; endsequence

  property p_write_answer; s_write_taken |-> ##[1:2] s_axi_bvalid; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer missing");
  property p_read_answer; s_read_taken |-> ##[1:2] s_axi_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer missing");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while answer pending");
  property p_pull_excl; (port_one_pullup_on & port_one_oe) == 8'h00; endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("pull-up on a driven pin");
  property p_p2_drive; (port_two_out & ~port_two_oe) == 8'h00; endproperty
  a_p2_drive: assert property (p_p2_drive) else $error("port two high on undriven pin");
  property p_rsvd_pins; !port_one_oe[3] && !port_one_pullup_on[3] && port_two_oe[7:3] == 5'h00; endproperty
  a_rsvd_pins: assert property (p_rsvd_pins) else $error("unused pin bit active");
  property p_trig_pair; ext_interrupt_line_c == timer_trigger_input; endproperty
  a_trig_pair: assert property (p_trig_pair) else $error("trigger and interrupt differ");
  property p_irq_src; !ext_interrupt_line_a |-> !$past(port_one_in[4]) && !port_one_oe[4]; endproperty
  a_irq_src: assert property (p_irq_src) else $error("interrupt line a not from pin");
  property p_trig_src; !timer_trigger_input |-> !$past(port_one_in[7]) && !port_one_oe[7]; endproperty
  a_trig_src: assert property (p_trig_src) else $error("trigger not from pin");
  property p_rd_one; s_axi_rvalid && rd_addr_r == 8'h04 |-> s_axi_rdata[3]; endproperty
  a_rd_one: assert property (p_rd_one) else $error("latch bit 3 reads 0");
  property p_rd_two; s_axi_rvalid && rd_addr_r == 8'h10 |-> s_axi_rdata[7:3] == 5'h1F; endproperty
  a_rd_two: assert property (p_rd_two) else $error("port two upper bits not 1");
  property p_reset; $rose(aresetn) |=> port_one_oe == 8'h00 && port_two_oe == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("pins driven after reset");
endmodule

bind gpio_ports_one_and_two gpio_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rdata, .port_one_in, .port_one_oe, .port_one_pullup_on, .port_two_oe,
  .port_two_out, .ext_interrupt_line_a, .ext_interrupt_line_c, .timer_trigger_input
);
`default_nettype wire

// *** verif/tb_gpio_ports_one_and_two.sv ***
// Testbench: register access, direction, pull-up and alternate-function scenarios
`timescale 1ns/1ns
`default_nettype none
module tb_gpio_ports_one_and_two;
  localparam logic [7:0] D1 = gpio_pkg::PORT_ONE_DIRECTION_OFS;
  localparam logic [7:0] L1 = gpio_pkg::PORT_ONE_OUTPUT_LATCH_OFS;
  localparam logic [7:0] U1 = gpio_pkg::PORT_ONE_PULLUP_ENABLE_OFS;
  localparam logic [7:0] D2 = gpio_pkg::PORT_TWO_DIRECTION_OFS;
  localparam logic [7:0] L2 = gpio_pkg::PORT_TWO_OUTPUT_LATCH_OFS;
  localparam logic [7:0] FN = gpio_pkg::PIN_FUNCTION_SELECT_OFS;
  localparam logic [1:0] OK = gpio_pkg::RESP_OKAY;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  port_one_in, port_one_out, port_one_oe, port_one_pullup_on;
  logic [7:0]  port_two_in, port_two_out, port_two_oe;
  logic        ext_interrupt_line_a, ext_interrupt_line_c, timer_trigger_input;
  logic        serial_unit_txd = 1'b0, serial_unit_rx_enable = 1'b0;
  logic        serial_unit_clk_enable = 1'b0, serial_unit_clk_out = 1'b0, serial_unit_clk_oe = 1'b0;
  logic [7:0]  drv1_en = 8'h00, drv1_v = 8'h00, drv2_en = 8'h00, drv2_v = 8'h00;
  int          err_count = 0, n_compared = 0, cyc = 0;

  gpio_ports_one_and_two DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_one_in, .port_one_out,
    .port_one_oe, .port_one_pullup_on, .port_two_in, .port_two_out, .port_two_oe,
    .ext_interrupt_line_a, .ext_interrupt_line_c, .timer_trigger_input, .serial_unit_txd,
    .serial_unit_rx_enable, .serial_unit_clk_enable, .serial_unit_clk_out, .serial_unit_clk_oe);
  gpio_board u_board (.aclk, .p1_oe(port_one_oe), .p1_out(port_one_out),
    .p1_pull(port_one_pullup_on), .p2_oe(port_two_oe), .p2_out(port_two_out), .drv1_en,
    .drv1_v, .drv2_en, .drv2_v, .p1_lvl(port_one_in), .p2_lvl(port_two_in));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t pins got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    n_compared++;
    if (s_axi_bresp !== er) begin
      err_count++;
      $display("BAD %0t write %h resp %h", $time, a, s_axi_bresp);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    n_compared++;
    if (s_axi_rdata !== {24'h0, e} || s_axi_rresp !== er) begin
      err_count++;
      $display("BAD %0t read %h got %h exp %h", $time, a, s_axi_rdata, e);
    end
  endtask
  task settle;
    repeat (2) @(posedge aclk);
  endtask
  task do_reset;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset_vals;
    do_reset;
    drv1_en <= 8'hFF;
    drv1_v <= 8'hA5;
    drv2_en <= 8'hFF;
    drv2_v <= 8'h05;
    settle;
    chk(port_one_oe | port_one_pullup_on | port_two_oe, 8'h00);
    rd(D1, 8'h00, OK);
    rd(L1, 8'hAD, OK);
    rd(U1, 8'h08, OK);
    rd(D2, 8'h00, OK);
    rd(L2, 8'hFD, OK);
    rd(FN, 8'h08, OK);
    rd(8'h40, 8'h00, gpio_pkg::RESP_SLVERR);
    wr(8'h40, 8'hFF, gpio_pkg::RESP_SLVERR);
    $display("t_reset_vals done");
  endtask
  task t_port_one;
    wr(D1, 8'hFF, OK);
    wr(L1, 8'h5A, OK);
    settle;
    chk(port_one_oe, 8'hF7);
    chk(port_one_out, 8'h52);
    rd(L1, 8'h5A, OK);
    drv1_v <= 8'hC0;
    wr(D1, 8'h0F, OK);
    settle;
    chk(port_one_oe, 8'h07);
    chk(port_one_out, 8'h02);
    rd(L1, 8'hCA, OK);
    $display("t_port_one done");
  endtask
  task t_pullup;
    drv1_en <= 8'h00;
    wr(U1, 8'hFF, OK);
    settle;
    chk(port_one_pullup_on, 8'hF0);
    rd(U1, 8'hFF, OK);
    wr(D1, 8'h00, OK);
    settle;
    chk(port_one_pullup_on, 8'hF7);
    rd(L1, 8'hFF, OK);
    wr(U1, 8'h00, OK);
    settle;
    chk(port_one_pullup_on, 8'h00);
    $display("t_pullup done");
  endtask
  task t_alt_fn;
    drv1_en <= 8'hFF;
    drv1_v <= 8'h00;
    wr(D1, 8'hF7, OK);
    wr(FN, 8'hFF, OK);
    settle;
    chk(port_one_oe, 8'h67);
    chk({5'h0, ext_interrupt_line_a, ext_interrupt_line_c, timer_trigger_input}, 8'h00);
    rd(FN, 8'h9A, OK);
    rd(L1, 8'h5A, OK);
    drv1_v <= 8'h90;
    serial_unit_txd <= 1'b1;
    settle;
    chk({5'h0, ext_interrupt_line_a, ext_interrupt_line_c, timer_trigger_input}, 8'h07);
    chk(port_two_oe & port_two_out, 8'h04);
    serial_unit_rx_enable <= 1'b1;
    serial_unit_clk_enable <= 1'b1;
    serial_unit_clk_out <= 1'b1;
    serial_unit_clk_oe <= 1'b1;
    wr(D2, 8'h07, OK);
    settle;
    chk(port_two_oe, 8'h05);
    chk(port_two_out, 8'h05);
    serial_unit_rx_enable <= 1'b0;
    serial_unit_clk_enable <= 1'b0;
    wr(FN, 8'h00, OK);
    $display("t_alt_fn done");
  endtask
  task t_port_two;
    drv2_v <= 8'h00;
    wr(D2, 8'h05, OK);
    wr(L2, 8'h06, OK);
    settle;
    chk(port_two_oe, 8'h05);
    chk(port_two_out, 8'h04);
    rd(L2, 8'hFC, OK);
    s_axi_wstrb <= 4'hE;
    wr(L2, 8'h00, OK);
    s_axi_wstrb <= 4'hF;
    rd(L2, 8'hFC, OK);
    $display("t_port_two done");
  endtask
  task t_mid_reset;
    wr(D1, 8'h00, OK);
    wr(U1, 8'hFF, OK);
    do_reset;
    settle;
    chk(port_one_pullup_on | port_one_oe | port_two_oe, 8'h00);
    rd(U1, 8'h08, OK);
    $display("t_mid_reset done");
  endtask

  initial begin
    t_reset_vals;
    t_port_one;
    t_pullup;
    t_alt_fn;
    t_port_two;
    t_mid_reset;
    tally_and_finish;
  end
endmodule
`default_nettype wire
